//--- core/irq_system.sv
// Functional notes
// [R01] Test pending at fetch end, save, redirect
// [R02] Entry stores bypass storage protection
// [R03] Manual unmasked, needs enable, self clears
// [R04] Taking interrupt in program state enters monitor
// [R05] Overflow on adder sign carry mismatch
// [R06] Divide fault: quotient, zero, unnormalized divisor
// [R07] Exponent beyond plus/minus 1777 octal, or op
// [R08] Bad digit, sign or zone sets decimal
// [R09] Carry, length, conversion, ASCII, op set decimal
// [R10] Search/move completion raises maskable interrupt
// [R11] Clock match to compare value raises interrupt
// [R12] Channel end-of-block or record interrupt
// [R13] Sixty-four equipment lines, level requests
// [R14] Peer interrupt unmasked, clears on recognition
// [R15] Program state traps halt, regfile, privileged ops
// [R16] Executive unmasked, above internal faults
// [R17] Parity highest, recognized at fetch/address read
// [R18] Parity stop halts and overrides interrupt
// [R19] Error address word to location 00020
// [R20] Error code to 00021, fetch there
// [R21] Error code table by source and kind
// [R22] Further storage errors ignored until disable
// [R23] Enable/disable ops; entry disables
// [R24] Fixed priority scan, lowest number wins
module irq_system
  import irq_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  instruction_fetch_cycle,
  input  wire logic                  address_read_cycle,
  input  wire logic                  cycle_end,
  input  wire logic [14:0]           cur_addr,
  input  wire logic [14:0]           next_addr,
  input  wire logic                  interrupt_enable_op,
  input  wire logic                  interrupt_disable_op,
  input  wire logic                  set_float_fault_op,
  input  wire logic                  set_decimal_fault_op,
  input  wire fault_in_s             faults,
  input  wire logic                  search_done,
  input  wire logic                  move_done,
  input  wire logic [23:0]           rtc_value,
  input  wire logic [CHANNELS-1:0]   chan_end_block,
  input  wire logic [CHANNELS-1:0]   chan_end_record,
  input  wire logic [CHANNELS*8-1:0] equip_line,
  input  wire logic                  manual_switch,
  input  wire logic                  interrupt_peer_op,
  input  wire logic                  executive_mode,
  input  wire logic                  enter_program_state,
  input  wire logic                  op_valid,
  input  wire logic [5:0]            op_code,
  input  wire logic [2:0]            op_sub,
  input  wire logic                  op_regfile,
  input  wire logic [5:0]            op_regfile_loc,
  input  wire mem_err_s              mem_err,
  output entry_s                     entry,
  output err_store_s                 err_store,
  output logic                       program_state,
  output logic                       parity_halt,
  output logic                       int_enabled
);

  initial begin
    if (CHANNELS < 1 || CHANNELS > 8) $error("CHANNELS must be 1 to 8");
  end

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [6:0]  mask;
  logic [7:0]  chan_en;
  logic [23:0] rtc_cmp;
  logic [1:0]  mode;
  logic [11:0] last_code;
  logic [NUM_PRIO-1:0] pend;
  logic [3:0]  fault;
  logic        sm_pend, rtc_pend, manual_pend, peer_pend, exec_pend;
  logic        par_pend, par_lock;
  logic [CHANNELS-1:0] chan_pend;
  logic [6:0]  last_prio;
  logic        sel;

  assign sel = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= sel && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (sel && !hwrite) begin
      unique case (haddr[7:0])
        STATUS_OFS:  hrdata <= {9'h000, last_prio, fault, sm_pend,
                                rtc_pend, manual_pend, peer_pend,
                                exec_pend, par_pend, par_lock,
                                parity_halt, program_state,
                                int_enabled, 2'h0};
        MASK_OFS:    hrdata <= 32'(mask);
        CHAN_OFS:    hrdata <= 32'(chan_en);
        RTC_CMP_OFS: hrdata <= 32'(rtc_cmp);
        MODE_OFS:    hrdata <= 32'(mode);
        ERR_OFS:     hrdata <= 32'(last_code);
        default:     hrdata <= '0;
      endcase
    end
  end

  logic wr_clear;
  assign wr_clear = wr_pend && wr_addr == CLEAR_OFS;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask    <= MASK_RST;
      chan_en <= CHAN_RST;
      rtc_cmp <= RTC_CMP_RST;
      mode    <= MODE_RST;
    end else if (wr_pend) begin
      if (wr_addr == MASK_OFS)    mask    <= hwdata[6:0];
      if (wr_addr == CHAN_OFS)    chan_en <= hwdata[7:0];
      if (wr_addr == RTC_CMP_OFS) rtc_cmp <= hwdata[23:0];
      // Stop wins: modes stay exclusive
      if (wr_addr == MODE_OFS)
        mode <= hwdata[1] ? 2'h2 : hwdata[1:0]; // R18
    end
  end

  // ------------------------------------------------------------
  // Fault detection
  // ------------------------------------------------------------
  logic [3:0] fault_set;
  logic       ascii_bad, conv_bad, char_bad;

  assign char_bad = faults.bcd_valid && (faults.bcd_is_sign ?
                    faults.bcd_char[3:0] > SIGN_MAX :
                    (faults.bcd_char[3:0] > DIGIT_MAX ||
                     faults.bcd_char[5:4] != 2'h0)); // R08
  assign conv_bad = faults.conv_valid &&
                    faults.conv_len > BCD_CONV_MAX; // R09
  assign ascii_bad = faults.ascii_valid &&
                     faults.ascii_char[5] == faults.ascii_char[6]; // R09

  always_comb begin
    fault_set[0] = faults.add_valid &&
                   (faults.add_sign_cin ^ faults.add_sign_cout); // R05
    fault_set[1] = faults.div_quot_ovf || (faults.fdiv_valid &&
                   (faults.fdiv_zero || faults.fdiv_unnorm)); // R06
    fault_set[2] = set_float_fault_op || (faults.exp_valid &&
                   (faults.exponent > EXP_MAX ||
                    faults.exponent < -EXP_MAX)); // R07
    fault_set[3] = set_decimal_fault_op || char_bad || conv_bad ||
                   ascii_bad || (faults.bcd_valid &&
                   (faults.bcd_carry || faults.bcd_len_bad)); // R09
  end

  // ------------------------------------------------------------
  // Pending conditions (set wins over clear)
  // ------------------------------------------------------------
  logic take;
  logic [6:0] win;
  logic exec_trap;

  assign exec_trap = op_valid && executive_mode && program_state &&
    ((op_code == OP_HALT) ||
     (op_regfile && op_regfile_loc <= REGF_PROT_MAX) ||
     (op_code >= OP_PRIV_MIN && !(op_code == 6'h3f &&
      (op_sub == OP_SUB_FLT || op_sub == OP_SUB_BCD)))); // R15
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fault   <= 4'h0;
      sm_pend <= 1'b0;
      rtc_pend <= 1'b0;
    end else begin
      fault   <= fault_set | (fault & ~(wr_clear ? hwdata[3:0] : 4'h0));
      sm_pend <= (search_done || move_done) ||
                 (sm_pend && !(wr_clear && hwdata[4])); // R10
      rtc_pend <= (rtc_value == rtc_cmp) ||
                  (rtc_pend && !(wr_clear && hwdata[5])); // R11
    end
  end

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_chan
      always_ff @(posedge sys_clk) begin
        if (sys_rst) chan_pend[c] <= 1'b0;
        else chan_pend[c] <= (chan_en[c] && (chan_end_block[c] ||
          chan_end_record[c])) || (chan_pend[c] &&
          !(wr_clear && hwdata[8 + c])); // R12
      end
    end
  endgenerate

  logic manual_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      manual_q    <= 1'b0;
      manual_pend <= 1'b0;
      peer_pend   <= 1'b0;
      exec_pend   <= 1'b0;
    end else begin
      manual_q    <= manual_switch;
      manual_pend <= (manual_switch && !manual_q) ||
        (manual_pend && !(take && win == 7'(P_MANUAL))); // R03
      peer_pend   <= interrupt_peer_op ||
        (peer_pend && !(take && win == 7'(P_PEER))); // R14
      exec_pend   <= exec_trap ||
        (exec_pend && !(take && win == 7'(P_EXEC))); // R16
    end
  end

  // ------------------------------------------------------------
  // Storage error capture
  // ------------------------------------------------------------
  logic [11:0] err_code;
  always_comb begin
    unique case (mem_err.src)
      ERR_CHANNEL: err_code = {6'h00, mem_err.channel, 3'h0};
      ERR_SEARCH:  err_code = {6'h01, 3'h0, 3'h0};
      ERR_MOVE:    err_code = {6'h01, 3'h1, 3'h0};
      ERR_TWR:     err_code = {6'h01, 3'h3, 3'h0};
      ERR_FETCH:   err_code = {9'h000, 3'h1};
      ERR_ADDR:    err_code = {6'h00, 3'h2, 3'h1};
      default:     err_code = {9'h000, 3'h5};
    endcase
    err_code[1] = !mem_err.no_response; // R21
  end
  logic par_event;
  assign par_event = mem_err.valid && !par_lock; // R22
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      par_lock    <= 1'b0;
      par_pend    <= 1'b0;
      parity_halt <= 1'b0;
      last_code   <= 12'h000;
      err_store   <= '0;
    end else begin
      err_store.valid <= 1'b0;
      if (par_event) begin
        par_lock  <= 1'b1;
        last_code <= err_code;
        if (mode[1]) parity_halt <= 1'b1; // R18
        else if (mode[0]) begin
          par_pend <= 1'b1;
          err_store.addr_word <= mem_err.block_ctl ? next_addr
                                                   : cur_addr; // R19
          err_store.code <= err_code; // R20
        end
      end else if (interrupt_disable_op) begin
        par_lock <= 1'b0; // R22
      end
      if (take && win == 7'(P_PARITY)) begin
        par_pend <= 1'b0;
        err_store.valid <= 1'b1; // R20
      end
    end
  end

  // ------------------------------------------------------------
  // Priority scan and entry
  // ------------------------------------------------------------
  always_comb begin
    pend = '0;
    pend[P_PARITY] = par_pend; // R17
    pend[P_EXEC]   = exec_pend; // R16
    pend[P_OVF]    = fault[0] && mask[M_OVF];
    pend[P_DIV]    = fault[1] && mask[M_DIV];
    pend[P_EXP]    = fault[2] && mask[M_EXP];
    pend[P_BCD]    = fault[3] && mask[M_BCD];
    for (int l = 0; l < 8; l++)
      for (int k = 0; k < CHANNELS; k++)
        pend[P_EQUIP + l * 8 + k] = equip_line[k * 8 + l] &&
                                    mask[M_EQ]; // R13
    for (int k = 0; k < CHANNELS; k++)
      pend[P_CHAN + k] = chan_pend[k];
    pend[P_SM]     = sm_pend && mask[M_SM];
    pend[P_RTC]    = rtc_pend && mask[M_RTC];
    pend[P_MANUAL] = manual_pend;
    pend[P_PEER]   = peer_pend;
  end

  always_comb begin
    win = 7'h00;
    for (int i = NUM_PRIO - 1; i >= 0; i--)
      if (pend[i]) win = 7'(i); // R24
  end
  // Parity is also taken at address read end
  assign take = int_enabled && cycle_end && |pend &&
    (instruction_fetch_cycle ||
     (address_read_cycle && win == 7'(P_PARITY))); // R01 R17
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      entry     <= '0;
      last_prio <= 7'h00;
    end else begin
      entry.take        <= take; // R01
      entry.force_store <= take; // R02
      if (take) begin
        entry.prio      <= win + 7'h01;
        entry.save_addr <= cur_addr;
        last_prio       <= win + 7'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) int_enabled <= 1'b0;
    else if (take || interrupt_disable_op) int_enabled <= 1'b0; // R23
    else if (interrupt_enable_op) int_enabled <= 1'b1; // R23
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) program_state <= 1'b0;
    else if (take) program_state <= 1'b0; // R04
    else if (enter_program_state && executive_mode)
      program_state <= 1'b1;
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking chk_clk @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  a_entry_disables: assert property (take |=> !int_enabled) // R23
    else $error("entry kept enable");
  a_entry_monitor: assert property (take |=> // R04
    !program_state && entry.take) else $error("no monitor entry");
  a_force_store: assert property (entry.take |-> entry.force_store) // R02
    else $error("store not forced");
  a_no_take_off: assert property (!int_enabled |=> !entry.take) // R01
    else $error("taken while disabled");
  a_parity_first: assert property (take && par_pend |=> // R17
    entry.prio == 7'h01) else $error("parity not first");
  a_exec_over: assert property (take && exec_pend && !par_pend |=> // R16
    entry.prio == 7'h04) else $error("executive outranked");
  a_manual_clear: assert property (take && win == 7'(P_MANUAL) && // R03
    !(manual_switch && !manual_q) |=> !manual_pend) else $error("manual kept");
  a_par_lock: assert property (par_lock && !interrupt_disable_op |=> // R22
    par_lock && $stable(last_code)) else $error("lock lost");
  a_stop_halts: assert property (par_event && mode[1] && !par_pend |=> // R18
    (parity_halt && !par_pend)[*2]) else $error("no stop halt");
  a_ovf_set: assert property (fault_set[0] |=> fault[0]) // R05
    else $error("overflow lost");

endmodule

//--- core/irq_pkg.sv
package irq_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS  = 8'h00;
  localparam logic [7:0] MASK_OFS    = 8'h04;
  localparam logic [7:0] CHAN_OFS    = 8'h08;
  localparam logic [7:0] RTC_CMP_OFS = 8'h0c;
  localparam logic [7:0] CLEAR_OFS   = 8'h10;
  localparam logic [7:0] MODE_OFS    = 8'h14;
  localparam logic [7:0] ERR_OFS     = 8'h18;

  localparam logic [6:0]  MASK_RST    = 7'h00;
  localparam logic [7:0]  CHAN_RST    = 8'h00;
  localparam logic [23:0] RTC_CMP_RST = 24'h000000;
  localparam logic [1:0]  MODE_RST    = 2'h1;

  // Mask bit positions
  localparam int M_OVF = 0;
  localparam int M_DIV = 1;
  localparam int M_EXP = 2;
  localparam int M_BCD = 3;
  localparam int M_SM  = 4;
  localparam int M_RTC = 5;
  localparam int M_EQ  = 6;

  // ------------------------------------------------------------
  // Priority slots (index = priority - 1)
  // ------------------------------------------------------------
  localparam int NUM_PRIO  = 85;
  localparam int P_PARITY  = 0;
  localparam int P_EXEC    = 3;
  localparam int P_OVF     = 4;
  localparam int P_DIV     = 5;
  localparam int P_EXP     = 6;
  localparam int P_BCD     = 7;
  localparam int P_EQUIP   = 8;
  localparam int P_CHAN    = 72;
  localparam int P_SM      = 80;
  localparam int P_RTC     = 81;
  localparam int P_MANUAL  = 82;
  localparam int P_PEER    = 83;

  // ------------------------------------------------------------
  // Fixed storage locations and limits
  // ------------------------------------------------------------
  localparam logic [14:0] ERR_ADDR_LOC = 15'h0010;
  localparam logic [14:0] ERR_CODE_LOC = 15'h0011;
  localparam logic signed [12:0] EXP_MAX = 13'sh03ff;
  localparam logic [4:0]  BCD_CONV_MAX = 5'h0e;
  localparam logic [3:0]  DIGIT_MAX    = 4'h9;
  localparam logic [3:0]  SIGN_MAX     = 4'ha;
  localparam logic [5:0]  REGF_PROT_MAX = 6'h1f;
  localparam logic [5:0]  OP_PRIV_MIN  = 6'h39;
  localparam logic [2:0]  OP_SUB_FLT   = 3'h1;
  localparam logic [2:0]  OP_SUB_BCD   = 3'h2;
  localparam logic [5:0]  OP_HALT      = 6'h00;

  typedef enum logic [2:0] {
    ERR_CHANNEL, ERR_SEARCH, ERR_MOVE, ERR_TWR,
    ERR_FETCH, ERR_ADDR, ERR_OPERAND
  } err_src_e;

  typedef struct packed {
    logic       valid;
    logic       no_response;
    logic       block_ctl;
    err_src_e   src;
    logic [2:0] channel;
  } mem_err_s;

  typedef struct packed {
    logic              add_valid;
    logic              add_sign_cin;
    logic              add_sign_cout;
    logic              div_quot_ovf;
    logic              fdiv_valid;
    logic              fdiv_zero;
    logic              fdiv_unnorm;
    logic              exp_valid;
    logic signed [12:0] exponent;
    logic              bcd_valid;
    logic              bcd_is_sign;
    logic [5:0]        bcd_char;
    logic              bcd_carry;
    logic              bcd_len_bad;
    logic [4:0]        conv_len;
    logic              conv_valid;
    logic              ascii_valid;
    logic [6:0]        ascii_char;
  } fault_in_s;

  typedef struct packed {
    logic       take;
    logic [6:0] prio;
    logic       force_store;
    logic [14:0] save_addr;
  } entry_s;

  typedef struct packed {
    logic        valid;
    logic [14:0] addr_word;
    logic [11:0] code;
  } err_store_s;

endpackage

//--- verif/equip_ctl_model.sv
module equip_ctl_model (
  input  wire logic        sys_clk,
  input  wire logic        raise,
  input  wire logic        drop,
  input  wire logic [5:0]  line_sel,
  input  wire logic        eob,
  input  wire logic        eor,
  input  wire logic [2:0]  chan_sel,
  output logic      [63:0] equip_line = '0,
  output logic      [7:0]  chan_end_block = '0,
  output logic      [7:0]  chan_end_record = '0
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Controller lines and channel events
  // ----------------------------------------
  // A controller keeps asking until someone drops its line
  always @(posedge sys_clk) begin
    if (raise)
      equip_line[line_sel] <= 1'h1;
    if (drop)
      equip_line[line_sel] <= 1'h0;
    chan_end_block <= eob ? 8'h01 << chan_sel : 8'h00;
    chan_end_record <= eor ? 8'h01 << chan_sel : 8'h00;
  end
endmodule

//--- verif/irq_system_test.sv
module irq_system_test
  import irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        sys_clk = '0;
  logic        sys_rst = '1;
  logic        hsel = '0, hwrite = '0, hready, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic        instruction_fetch_cycle = '0, address_read_cycle = '0;
  logic        cycle_end = '0, interrupt_enable_op = '0;
  logic        interrupt_disable_op = '0, set_float_fault_op = '0;
  logic        set_decimal_fault_op = '0, search_done = '0, move_done = '0;
  logic [14:0] cur_addr = 15'h1234, next_addr = 15'h0567;
  fault_in_s   faults = '0;
  logic [23:0] rtc_value = '0;
  logic [7:0]  chan_end_block, chan_end_record;
  logic [63:0] equip_line;
  logic        manual_switch = '0, interrupt_peer_op = '0;
  logic        executive_mode = '0, enter_program_state = '0;
  logic        op_valid = '0, op_regfile = '0;
  logic [5:0]  op_code = '0, op_regfile_loc = '0, line_sel = '0;
  logic [2:0]  op_sub = '0, chan_sel = '0;
  mem_err_s    mem_err = '0;
  entry_s      entry;
  err_store_s  err_store, seen_err;
  logic        program_state, parity_halt, int_enabled;
  logic        raise = '0, drop = '0, eob = '0, eor = '0;
  int          err_total = 0, n_checks = 0;
  mem_err_s    me_tab [9] = '{
    '{'1, '1, '1, ERR_CHANNEL, 3'h3}, '{'1, '0, '1, ERR_CHANNEL, 3'h3},
    '{'1, '1, '1, ERR_SEARCH, 3'h0}, '{'1, '0, '1, ERR_MOVE, 3'h0},
    '{'1, '1, '1, ERR_TWR, 3'h0}, '{'1, '1, '0, ERR_FETCH, 3'h0},
    '{'1, '0, '0, ERR_ADDR, 3'h0}, '{'1, '1, '0, ERR_OPERAND, 3'h0},
    '{'1, '0, '0, ERR_OPERAND, 3'h0}};
  logic [11:0] code_tab [9] = '{12'h018, 12'h01a, 12'h040, 12'h04a,
    12'h058, 12'h001, 12'h013, 12'h005, 12'h007};

  assign hready = hreadyout;
  always #5 sys_clk = ~sys_clk;

  irq_system irq_system_i (.*);
  equip_ctl_model equip_ctl_model_i (.*);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= '1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= '0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus('1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus('0, a, 32'h0, x);
    check(x, e);
  endtask

  task automatic ops(input logic en, input logic dis);
    @(posedge sys_clk);
    interrupt_enable_op <= en;
    interrupt_disable_op <= dis;
    @(posedge sys_clk);
    interrupt_enable_op <= '0;
    interrupt_disable_op <= '0;
  endtask

  // A p of zero: no entry allowed
  task automatic fetch(input logic ar, input logic [6:0] p);
    logic got = '0;
    seen_err = '0;
    @(posedge sys_clk);
    instruction_fetch_cycle <= ~ar;
    address_read_cycle <= ar;
    cycle_end <= '1;
    @(posedge sys_clk);
    cycle_end <= '0;
    instruction_fetch_cycle <= '0;
    address_read_cycle <= '0;
    repeat (3) begin
      @(posedge sys_clk);
      if (entry.take === 1'h1 && !got) begin
        got = '1;
        seen_err = err_store;
        check(entry.prio, p);
        check(entry.save_addr, cur_addr);
        check(entry.force_store, 1'h1);
      end
    end
    if (!got)
      check(7'h0, p);
    else
      check({int_enabled, program_state}, 2'h0);
  endtask

  task automatic fault_case(input fault_in_s f, input logic [3:0] s,
                            input logic [6:0] p);
    ops('1, '0);
    @(posedge sys_clk);
    faults <= f;
    {set_float_fault_op, set_decimal_fault_op, search_done, move_done} <= s;
    @(posedge sys_clk);
    faults <= '0;
    {set_float_fault_op, set_decimal_fault_op, search_done, move_done} <= '0;
    fetch('0, p);
    wr(CLEAR_OFS, 32'h0000ff3f);
  endtask

  task automatic attempt(input logic pe, input logic [5:0] oc,
    input logic [2:0] sb, input logic rf, input logic [5:0] loc,
    input logic [6:0] p);
    @(posedge sys_clk);
    enter_program_state <= pe;
    @(posedge sys_clk);
    enter_program_state <= '0;
    op_valid <= '1;
    op_code <= oc;
    op_sub <= sb;
    op_regfile <= rf;
    op_regfile_loc <= loc;
    @(posedge sys_clk);
    op_valid <= '0;
    ops('1, '0);
    fetch('0, p);
  endtask

  task automatic model(input logic [3:0] c, input logic [5:0] l,
                       input logic [2:0] ch);
    @(posedge sys_clk);
    {raise, drop, eob, eor} <= c;
    line_sel <= l;
    chan_sel <= ch;
    @(posedge sys_clk);
    {raise, drop, eob, eor} <= '0;
  endtask

  task automatic perr(input mem_err_s m);
    @(posedge sys_clk);
    mem_err <= m;
    @(posedge sys_clk);
    mem_err <= '0;
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= '0;
    @(posedge sys_clk);
    check({hreadyout, hresp, int_enabled, parity_halt}, 4'h8);
    rd_chk(MODE_OFS, 32'h1);
    rd_chk(CHAN_OFS, 32'h0);
    rd_chk(RTC_CMP_OFS, 32'h0);
    wr(8'h1c, 32'hffffffff);
    rd_chk(8'h1c, 32'h0);
    fault_case('{add_valid: '1, add_sign_cin: '1, default: '0}, 0, 0);
    ops('0, '1);
    manual_switch <= '1;
    interrupt_peer_op <= '1;
    @(posedge sys_clk);
    interrupt_peer_op <= '0;
    fetch('0, 7'h0);
    ops('1, '0);
    fetch('0, 7'h53);
    ops('1, '0);
    fetch('0, 7'h54);
    ops('1, '0);
    fetch('0, 7'h0);
    wr(MASK_OFS, 32'h7f);
    rd_chk(MASK_OFS, 32'h7f);
    wr(CHAN_OFS, 32'hff);
    wr(RTC_CMP_OFS, 32'h10);
    fault_case('{add_valid: '1, add_sign_cout: '1, default: '0}, 0, 5);
    fault_case('{add_valid: '1, default: '0}, 0, 0);
    fault_case('{div_quot_ovf: '1, default: '0}, 0, 6);
    fault_case('{fdiv_valid: '1, fdiv_zero: '1, default: '0}, 0, 6);
    fault_case('{fdiv_valid: '1, fdiv_unnorm: '1, default: '0}, 0, 6);
    fault_case('{exp_valid: '1, exponent: 13'h0400, default: '0}, 0, 7);
    fault_case('{exp_valid: '1, exponent: 13'h1c00, default: '0}, 0, 7);
    fault_case('{exp_valid: '1, exponent: 13'h03ff, default: '0}, 0, 0);
    fault_case('{exp_valid: '1, exponent: 13'h1c01, default: '0}, 0, 0);
    fault_case('0, 4'h8, 7);
    fault_case('{bcd_valid: '1, bcd_char: 6'h0a, default: '0}, 0, 8);
    fault_case('{bcd_valid: '1, bcd_char: 6'h09, default: '0}, 0, 0);
    fault_case('{bcd_valid: '1, bcd_is_sign: '1, bcd_char: 6'h0b,
                 default: '0}, 0, 8);
    fault_case('{bcd_valid: '1, bcd_is_sign: '1, bcd_char: 6'h0a,
                 default: '0}, 0, 0);
    fault_case('{bcd_valid: '1, bcd_char: 6'h10, default: '0}, 0, 8);
    fault_case('{bcd_valid: '1, bcd_carry: '1, default: '0}, 0, 8);
    fault_case('{bcd_valid: '1, bcd_len_bad: '1, default: '0}, 0, 8);
    fault_case('{conv_valid: '1, conv_len: 5'h0f, default: '0}, 0, 8);
    fault_case('{conv_valid: '1, conv_len: 5'h0e, default: '0}, 0, 0);
    fault_case('{ascii_valid: '1, ascii_char: 7'h60, default: '0}, 0, 8);
    fault_case('{ascii_valid: '1, ascii_char: 7'h10, default: '0}, 0, 8);
    fault_case('{ascii_valid: '1, ascii_char: 7'h30, default: '0}, 0, 0);
    fault_case('0, 4'h4, 8);
    fault_case('{add_valid: '1, add_sign_cin: '1, exp_valid: '1,
                 exponent: 13'h0400, default: '0}, 0, 5);
    fault_case('0, 4'h2, 7'h51);
    fault_case('0, 4'h1, 7'h51);
    rtc_value <= 24'h10;
    fault_case('0, 0, 7'h52);
    rtc_value <= 24'h11;
    wr(CLEAR_OFS, 32'h20);
    fault_case('0, 0, 0);
    model(4'h8, 6'h08, 3'h0);
    model(4'h8, 6'h01, 3'h0);
    ops('1, '0);
    fetch('0, 7'h0a);
    ops('1, '0);
    fetch('0, 7'h0a);
    model(4'h4, 6'h08, 3'h0);
    ops('1, '0);
    fetch('0, 7'h11);
    model(4'h4, 6'h01, 3'h0);
    model(4'h2, 6'h00, 3'h2);
    model(4'h1, 6'h00, 3'h0);
    ops('1, '0);
    fetch('0, 7'h49);
    wr(CLEAR_OFS, 32'h100);
    ops('1, '0);
    fetch('0, 7'h4b);
    wr(CLEAR_OFS, 32'h400);
    executive_mode <= '1;
    attempt('1, 6'h39, 3'h0, '0, 6'h00, 7'h04);
    attempt('1, 6'h3f, 3'h3, '0, 6'h00, 7'h04);
    attempt('1, 6'h3f, 3'h1, '0, 6'h00, 7'h00);
    attempt('1, 6'h3f, 3'h2, '0, 6'h00, 7'h00);
    attempt('1, 6'h38, 3'h0, '0, 6'h00, 7'h00);
    attempt('1, 6'h2b, 3'h0, '1, 6'h20, 7'h00);
    attempt('1, 6'h2b, 3'h0, '1, 6'h1f, 7'h04);
    check(program_state, 1'h0);
    faults <= '{add_valid: '1, add_sign_cin: '1, default: '0};
    attempt('1, OP_HALT, 3'h0, '0, 6'h00, 7'h04);
    faults <= '0;
    fault_case('0, 0, 5);
    attempt('0, OP_HALT, 3'h0, '0, 6'h00, 7'h00);
    for (int i = 0; i < 9; i++) begin
      ops('1, '0);
      perr(me_tab[i]);
      fetch(i == 6, 7'h01);
      check(seen_err.valid, 1'h1);
      check(seen_err.code, code_tab[i]);
      check(seen_err.addr_word,
            me_tab[i].block_ctl ? next_addr : cur_addr);
      ops('0, '1);
    end
    ops('1, '0);
    perr(me_tab[5]);
    fetch('0, 7'h01);
    ops('1, '0);
    perr(me_tab[5]);
    fetch('0, 7'h00);
    ops('0, '1);
    wr(MODE_OFS, 32'h3);
    ops('1, '0);
    perr(me_tab[5]);
    fetch('0, 7'h00);
    check(parity_halt, 1'h1);
    give_verdict();
  end
endmodule
